// >>> src/psdp_pkg.sv
package psdp_pkg;

    // ****************************************************************
    // Register map (byte addresses on the AXI4-Lite slave)
    // ****************************************************************
    localparam logic [7:0] PSDP_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSDP_STATUS_OFS = 8'h04;
    localparam logic [7:0] PSDP_WRCNT_OFS = 8'h08;
    localparam logic [7:0] PSDP_RDCNT_OFS = 8'h0C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int PSDP_CTRL_SLEEP_BIT = 0;
    localparam int PSDP_ST_ASLEEP_BIT = 0;
    localparam int PSDP_ST_INTERLEAVE_BIT = 1;
    localparam int PSDP_ST_READ_BIT = 2;
    localparam int PSDP_ST_WRITE_BIT = 3;
    localparam int PSDP_ST_DESEL_BIT = 4;
    localparam logic PSDP_CTRL_SLEEP_RST = 1'b0;
    localparam logic PSDP_MODE_RST = 1'b1;

    // ****************************************************************
    // Bus answers and geometry
    // ****************************************************************
    localparam logic [1:0] PSDP_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSDP_RESP_SLVERR = 2'h2;
    localparam int PSDP_LANE_BITS = 9;
    localparam int PSDP_BURST_BITS = 2;

    // Operation held in each pipeline stage
    typedef enum logic [1:0] {
        PSDP_OP_IDLE,
        PSDP_OP_READ,
        PSDP_OP_WRITE
    } psdp_op_t;

endpackage

// >>> src/psdp_burst_counter.sv
`timescale 1ns/1ps
`default_nettype none

module psdp_burst_counter
    import psdp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step_en,
    input wire logic load,
    input wire logic advance,
    input wire logic interleaved,
    input wire logic [psdp_pkg::PSDP_BURST_BITS-1:0] start,
    output logic [psdp_pkg::PSDP_BURST_BITS-1:0] low_addr
);

    logic [PSDP_BURST_BITS-1:0] start_r;
    logic [PSDP_BURST_BITS-1:0] count_r;
    logic [PSDP_BURST_BITS-1:0] start_nxt;
    logic [PSDP_BURST_BITS-1:0] count_nxt;

    // ****************************************************************
    // Burst order
    // ****************************************************************
    // Counter wraps naturally after four beats; no carry into upper bits
    assign low_addr = interleaved ? (start_r ^ count_r)
                                  : PSDP_BURST_BITS'(start_r + count_r);
    assign start_nxt = load ? start : start_r;
    assign count_nxt = load ? '0 : (advance ? PSDP_BURST_BITS'(count_r + 1'b1) : count_r);

    // State moves only on qualified edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_r <= '0;
            count_r <= '0;
        end else if (step_en) begin
            start_r <= start_nxt;
            count_r <= count_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> src/psdp_core.sv
`timescale 1ns/1ps
`default_nettype none

module psdp_core
    import psdp_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int LANES = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_qualify_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic write_enable_n,
    input wire logic advance_or_load,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic output_drive_permit_n,
    input wire logic burst_order_strap,
    input wire logic sleep_request,
    input wire logic [LANES*8-1:0] data_in,
    output logic [LANES*8-1:0] data_out,
    output logic data_oe,
    input wire logic [LANES-1:0] parity_lines_in,
    output logic [LANES-1:0] parity_lines_out,
    output logic parity_lines_oe,
    output logic sleep_active,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int WORD_W = LANES * PSDP_LANE_BITS;
    localparam int DEPTH = 1 << ADDR_W;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [WORD_W-1:0] mem [DEPTH];
    psdp_op_t op1_r;
    psdp_op_t op1_nxt;
    psdp_op_t op2_r;
    logic [ADDR_W-PSDP_BURST_BITS-1:0] base_r;
    logic [LANES-1:0] bw1_r;
    logic [LANES-1:0] bw2_r;
    logic [ADDR_W-1:0] addr2_r;
    logic [WORD_W-1:0] dout_r;
    logic mode_r;
    logic mode_taken_r;
    logic [1:0] sleep_sync_r;
    logic soft_sleep_r;
    logic [31:0] wr_count_r;
    logic [31:0] rd_count_r;
    logic step;
    logic selected;
    logic load_cmd;
    logic burst_cmd;
    logic [PSDP_BURST_BITS-1:0] low_addr;
    logic [ADDR_W-1:0] addr1;
    logic commit_write;
    logic forward_hit;
    logic [WORD_W-1:0] pin_word;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] wr_word;
    logic drive;
    logic asleep;

    // ****************************************************************
    // Qualification and command decode
    // ****************************************************************
    // A high qualify input masks the edge entirely, so nothing deselects
    assign asleep = sleep_sync_r[1];
    assign step = !clock_qualify_n;
    assign selected = !chip_select_first_n && chip_select_second
                      && !chip_select_third_n;
    assign load_cmd = !advance_or_load && selected;
    // Advance keeps the latched op type; selects and write enable ignored
    assign burst_cmd = advance_or_load && (op1_r != PSDP_OP_IDLE);

    // Next op for the address stage
    always_comb begin
        case ({load_cmd, burst_cmd})
            2'b10: op1_nxt = write_enable_n ? PSDP_OP_READ : PSDP_OP_WRITE;
            2'b01: op1_nxt = op1_r;
            default: op1_nxt = PSDP_OP_IDLE;
        endcase
    end

    // ****************************************************************
    // Burst order strap
    // ****************************************************************
    // Strap taken once after reset release; later changes are not followed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= PSDP_MODE_RST;
            mode_taken_r <= 1'b0;
        end else if (!mode_taken_r) begin
            mode_r <= burst_order_strap;
            mode_taken_r <= 1'b1;
        end
    end

    psdp_burst_counter u_burst (
        .aclk(aclk),
        .aresetn(aresetn),
        .step_en(step && !asleep),
        .load(load_cmd),
        .advance(burst_cmd),
        .interleaved(mode_r),
        .start(addr[PSDP_BURST_BITS-1:0]),
        .low_addr(low_addr)
    );

    assign addr1 = {base_r, low_addr};

    // ****************************************************************
    // Sleep
    // ****************************************************************
    // Two flops give the two-clock entry and exit and tame the async pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_sync_r <= 2'h0;
        end else begin
            sleep_sync_r <= {sleep_sync_r[0], sleep_request || soft_sleep_r};
        end
    end

    assign sleep_active = asleep;

    // ****************************************************************
    // Address and data pipeline
    // ****************************************************************
    // Pending work is dropped at sleep; the array itself is untouched
    always_ff @(posedge aclk) begin
        if (!aresetn || asleep) begin
            op1_r <= PSDP_OP_IDLE;
            op2_r <= PSDP_OP_IDLE;
            base_r <= '0;
            bw1_r <= '1;
            bw2_r <= '1;
            addr2_r <= '0;
        end else if (step) begin
            op1_r <= op1_nxt;
            if (load_cmd) begin
                base_r <= addr[ADDR_W-1:PSDP_BURST_BITS];
            end
            bw1_r <= byte_lane_write_n;
            op2_r <= op1_r;
            bw2_r <= bw1_r;
            addr2_r <= addr1;
        end
    end

    // Write data of stage two arrives on the pins and lands at this edge
    assign commit_write = step && !asleep && (op2_r == PSDP_OP_WRITE);
    // A read right behind a write to the same word sees the new bytes
    assign forward_hit = commit_write && (op1_r == PSDP_OP_READ) && (addr1 == addr2_r);

    // Each lane is eight data bits with its parity bit on top
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            localparam int LO = g * PSDP_LANE_BITS;
            assign pin_word[LO +: PSDP_LANE_BITS] =
                {parity_lines_in[g], data_in[g*8 +: 8]};
            assign rd_word[LO +: PSDP_LANE_BITS] = (forward_hit && !bw2_r[g])
                ? pin_word[LO +: PSDP_LANE_BITS] : mem[addr1][LO +: PSDP_LANE_BITS];
            assign data_out[g*8 +: 8] = dout_r[LO +: 8];
            assign parity_lines_out[g] = dout_r[LO + 8];

            // Lane stored only under its own select, parity included
            assign wr_word[LO +: PSDP_LANE_BITS] = bw2_r[g]
                ? mem[addr2_r][LO +: PSDP_LANE_BITS]
                : pin_word[LO +: PSDP_LANE_BITS];
        end
    endgenerate

    // Whole word written back, so the array keeps a single writer process
    always_ff @(posedge aclk) begin
        if (commit_write) begin
            mem[addr2_r] <= wr_word;
        end
    end

    // Output register loaded one qualified edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_r <= '0;
        end else if (step && !asleep && op1_r == PSDP_OP_READ) begin
            dout_r <= rd_word;
        end
    end

    // ****************************************************************
    // Output drive control
    // ****************************************************************
    // Only a read data phase drives; write, deselect and the first clock
    // after deselect all leave stage two idle or writing
    assign drive = (op2_r == PSDP_OP_READ)
                   && !output_drive_permit_n
                   && !asleep;
    assign data_oe = drive;
    assign parity_lines_oe = drive;

    // ****************************************************************
    // Activity counters
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_count_r <= '0;
            rd_count_r <= '0;
        end else begin
            if (commit_write) begin
                wr_count_r <= wr_count_r + 32'h0000_0001;
            end
            if (step && !asleep && op1_r == PSDP_OP_READ) begin
                rd_count_r <= rd_count_r + 32'h0000_0001;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_write;
    logic ar_take;
    logic wr_ctrl;
    logic wr_mapped;
    logic rd_mapped;
    logic [31:0] status_word;
    logic [31:0] rd_value;

    // Address decode shared by both directions
    function automatic logic psdp_mapped(input logic [7:0] a);
        psdp_mapped = (a == PSDP_CTRL_OFS) || (a == PSDP_STATUS_OFS)
                      || (a == PSDP_WRCNT_OFS) || (a == PSDP_RDCNT_OFS);
    endfunction

    // Address and data taken in either order, one write at a time
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wr_mapped = psdp_mapped(awaddr_r);
    assign wr_ctrl = do_write && (awaddr_r == PSDP_CTRL_OFS) && wstrb_r[0];
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= PSDP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_mapped ? PSDP_RESP_OKAY : PSDP_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Software sleep joins the pin ahead of the synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_sleep_r <= PSDP_CTRL_SLEEP_RST;
        end else if (wr_ctrl) begin
            soft_sleep_r <= wdata_r[PSDP_CTRL_SLEEP_BIT];
        end
    end

    // Read side: status shows live pipeline and sleep state
    assign status_word = 32'h0000_0000
                         | (32'(asleep) << PSDP_ST_ASLEEP_BIT)
                         | (32'(mode_r) << PSDP_ST_INTERLEAVE_BIT)
                         | (32'(op2_r == PSDP_OP_READ) << PSDP_ST_READ_BIT)
                         | (32'(op2_r == PSDP_OP_WRITE) << PSDP_ST_WRITE_BIT)
                         | (32'(op1_r == PSDP_OP_IDLE) << PSDP_ST_DESEL_BIT);
    assign rd_mapped = psdp_mapped(s_axi_araddr);
    assign rd_value = (s_axi_araddr == PSDP_CTRL_OFS) ? 32'(soft_sleep_r)
                    : (s_axi_araddr == PSDP_STATUS_OFS) ? status_word
                    : (s_axi_araddr == PSDP_WRCNT_OFS) ? wr_count_r
                    : (s_axi_araddr == PSDP_RDCNT_OFS) ? rd_count_r
                    : 32'h0000_0000;
    assign ar_take = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= PSDP_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_value;
            rresp_r <= rd_mapped ? PSDP_RESP_OKAY : PSDP_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> verification/psdp_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the data port
// ****************************************************************
module psdp_core_properties #(
    parameter int LANES = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_qualify_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic write_enable_n,
    input wire logic advance_or_load,
    input wire logic output_drive_permit_n,
    input wire logic sleep_request,
    input wire logic [LANES*8-1:0] data_out,
    input wire logic data_oe,
    input wire logic [LANES-1:0] parity_lines_out,
    input wire logic parity_lines_oe,
    input wire logic sleep_active,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    // Command decode; an asleep edge counts as unqualified
    wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    wire qual = !clock_qualify_n && !sleep_active;
    wire load_rd = sel && !advance_or_load && write_enable_n;
    wire load_wr = sel && !advance_or_load && !write_enable_n;
    wire desel = !sel && !advance_or_load;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    oe_permit_a:
        assert property (data_oe |-> !output_drive_permit_n)
        else $error("data driven without permit");
    parity_oe_a:
        assert property (parity_lines_oe == data_oe)
        else $error("parity enable differs from data enable");
    freeze_hold_a:
        assert property (clock_qualify_n && !sleep_active |=> $stable(data_out)
            && $stable(parity_lines_out))
        else $error("output moved on an unqualified edge");
    write_tristate_a:
        assert property (qual && load_wr ##1 qual |=> !data_oe && !parity_lines_oe)
        else $error("driven in write data cycle");
    read_drive_a:
        assert property (qual && load_rd ##1 qual |=> data_oe == !output_drive_permit_n)
        else $error("read data phase enable wrong");
    emerge_quiet_a:
        assert property (qual && desel ##1 qual |=> !data_oe && !parity_lines_oe)
        else $error("driven after deselect");
    sleep_quiet_a:
        assert property (sleep_active |-> !data_oe)
        else $error("driven while asleep");
    sleep_entry_a:
        assert property (sleep_request [*4] |-> sleep_active)
        else $error("sleep not entered in time");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
endmodule

bind psdp_core psdp_core_properties #(.LANES(LANES)) u_props (.*);
`default_nettype wire

// >>> verification/psdp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Memory controller model
// ****************************************************************
module psdp_ctl_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_qualify_n,
    input wire logic sleep_active,
    input wire logic [1:0] kind,
    input wire logic [3:0] cmd_addr,
    input wire logic [3:0] cmd_lanes_n,
    input wire logic [35:0] cmd_word,
    output logic chip_select_first_n,
    output logic chip_select_second,
    output logic chip_select_third_n,
    output logic write_enable_n,
    output logic advance_or_load,
    output logic [17:0] addr,
    output logic [3:0] byte_lane_write_n,
    output logic [35:0] drive_word,
    output logic drive_en
);
    logic w1_r, w2_r;
    logic [35:0] d1_r, d2_r, last_r;
    // Kind 0 deselect, 1 load read, 2 load write, 3 advance
    assign chip_select_first_n = (kind == 2'h0);
    assign chip_select_second = (kind != 2'h0);
    assign chip_select_third_n = (kind == 2'h0);
    assign write_enable_n = (kind != 2'h2);
    assign advance_or_load = (kind == 2'h3);
    assign addr = {14'h0, cmd_addr};
    assign byte_lane_write_n = cmd_lanes_n;
    // Write data goes out two qualified edges after its command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w1_r <= 1'b0;
            w2_r <= 1'b0;
        end else if (!clock_qualify_n && !sleep_active) begin
            w1_r <= (kind == 2'h2) || (kind == 2'h3 && w1_r);
            w2_r <= w1_r;
            d1_r <= cmd_word;
            d2_r <= d1_r;
        end
        last_r <= aresetn ? drive_word : 36'h0;
    end
    // Released lines toggle, so stale data never looks valid
    assign drive_en = w2_r;
    assign drive_word = w2_r ? d2_r : ~last_r;
endmodule
`default_nettype wire

// >>> verification/pipelined_sram_data_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pipelined_sram_data_port_tb_top;
    import psdp_pkg::*;
    logic aclk, aresetn, clock_qualify_n, output_drive_permit_n, burst_order_strap;
    logic sleep_request, stall_en, drive_en, data_oe, parity_lines_oe, sleep_active;
    logic chip_select_first_n, chip_select_second, chip_select_third_n;
    logic write_enable_n, advance_or_load;
    logic [1:0] kind, s_axi_bresp, s_axi_rresp, op1, op2, k1, s1, rr;
    logic [3:0] cmd_addr, cmd_lanes_n, byte_lane_write_n, parity_lines_out, a1, a2, ln1, ln2;
    logic [17:0] addr;
    logic [31:0] data_out, s_axi_wdata, s_axi_rdata, rd;
    logic [35:0] cmd_word, drive_word, bus_word, exp2;
    logic [35:0] ref_mem [0:15];
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] rnd_a, rnd_b;
    int err_total, check_count, cyc;

    // Wire level: the port drives in its read phase, else the controller
    assign bus_word = data_oe ? {parity_lines_out, data_out} : drive_word;

    psdp_core #(.ADDR_W(18), .LANES(4)) uut (.*, .data_in(bus_word[31:0]),
        .parity_lines_in(bus_word[35:32]), .s_axi_wstrb(4'hF));
    psdp_ctl_model ctl (.*);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [1:0] burst_low(input logic [1:0] s, k, input logic inter);
        return inter ? (s ^ k) : (s + k);
    endfunction

    task check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // Bus and memory drivers
    // ****************************************************************
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 0;
        w_done = 0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            aw_done |= s_axi_awvalid && s_axi_awready;
            w_done |= s_axi_wvalid && s_axi_wready;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Holds the command until a qualified edge has taken it
    task mem_op(input logic [1:0] k, input logic [3:0] a, input logic [3:0] ln);
        rnd_a = lfsr(rnd_a);
        kind <= k;
        cmd_addr <= a;
        cmd_lanes_n <= ln;
        cmd_word <= {rnd_a[3:0], rnd_a, rnd_a ^ 16'h5A5A};
        do @(posedge aclk); while (clock_qualify_n !== 1'b0 || sleep_active !== 1'b0);
    endtask
    task run_phase(input logic strap, input int n);
        aresetn <= 1'b0;
        stall_en <= 1'b0;
        kind <= 2'h0;
        burst_order_strap <= strap;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // Strap is taken at the first edge after release; read it after that
        @(posedge aclk);
        axi_rd(PSDP_STATUS_OFS);
        check(rd[PSDP_ST_INTERLEAVE_BIT], strap);
        stall_en <= 1'b1;
        for (int i = 0; i < 16; i++) mem_op((i % 4) ? 2'h3 : 2'h2, i[3:0], 4'h0);
        for (int i = 0; i < n; i++) mem_op(rnd_a[1:0], rnd_a[7:4], rnd_a[11:8]);
        repeat (3) mem_op(2'h0, 4'h0, 4'hF);
        stall_en <= 1'b0;
    endtask

    // ****************************************************************
    // Reference pipeline and comparisons
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn || sleep_active) begin
            op1 = 0;
            op2 = 0;
        end else if (!clock_qualify_n) begin
            // Write lands before the next read looks, so forwarding is covered
            if (op2 == 2) for (int g = 0; g < 4; g++) if (!ln2[g]) begin
                ref_mem[a2][8*g+:8] = bus_word[8*g+:8];
                ref_mem[a2][32+g] = bus_word[32+g];
            end
            op2 = op1;
            a2 = a1;
            ln2 = ln1;
            if (op2 == 1) exp2 = ref_mem[a2];
            if (!chip_select_first_n && chip_select_second && !chip_select_third_n
                && !advance_or_load) begin
                op1 = write_enable_n ? 2'h1 : 2'h2;
                a1 = addr[3:0];
                s1 = addr[1:0];
                k1 = 0;
            end else if (advance_or_load && op1 != 0) begin
                k1 = k1 + 2'h1;
                a1[1:0] = burst_low(s1, k1, burst_order_strap);
            end else op1 = 0;
            ln1 = byte_lane_write_n;
        end
    end
    always @(negedge aclk) if (aresetn) begin
        check(data_oe & drive_en, 1'b0);
        if (op2 == 1) begin
            check({parity_lines_out, data_out}, exp2);
            check(data_oe, !output_drive_permit_n);
        end else check(data_oe, 1'b0);
    end

    // Stalls and output permit drawn at random; also the hang limit
    always @(posedge aclk) begin
        rnd_b <= lfsr(rnd_b);
        clock_qualify_n <= stall_en && rnd_b[0] && rnd_b[1];
        output_drive_permit_n <= stall_en && rnd_b[2] && rnd_b[3] && rnd_b[4];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up;
        end
    end
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        {aresetn, clock_qualify_n, output_drive_permit_n, stall_en} = 4'h0;
        {kind, cmd_addr, cmd_lanes_n, cmd_word} = 46'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        burst_order_strap = 1'b1;
        sleep_request = 1'b0;
        rnd_a = 16'hF76B;
        rnd_b = lfsr(16'hF76B);
        err_total = 0;
        check_count = 0;
        cyc = 0;
        run_phase(1'b1, 300);
        axi_rd(8'h10);
        check({rr, rd}, {PSDP_RESP_SLVERR, 32'h0});
        sleep_request <= 1'b1;
        repeat (5) @(posedge aclk);
        check(sleep_active, 1'b1);
        sleep_request <= 1'b0;
        repeat (5) @(posedge aclk);
        check(sleep_active, 1'b0);
        axi_wr(PSDP_CTRL_OFS, 32'h1);
        axi_rd(PSDP_CTRL_OFS);
        check(rd, 32'h1);
        repeat (4) @(posedge aclk);
        check(sleep_active, 1'b1);
        axi_wr(PSDP_CTRL_OFS, 32'h0);
        repeat (5) @(posedge aclk);
        for (int i = 0; i < 16; i++) mem_op(2'h1, i[3:0], 4'hF);
        repeat (3) mem_op(2'h0, 4'h0, 4'hF);
        run_phase(1'b0, 150);
        wrap_up;
    end
endmodule
`default_nettype wire
